// ===== rtl/pbus_capture.sv
// Parallel bus capture, decode and logic trigger top
// Overview of operation
// - Bus width is one to sixteen lines, clamped to the available lines.
// - Each bus bit has its own input line selector.
// - Unclocked uses data lines only; clocked adds selectable clock and chip select.
// - Chip select enable decides whether chip select qualifies samples.
// - Chip select polarity is active high or active low.
// - Clocked data sampled on rising, falling or both clock edges.
// - Every qualifying clock edge starts a new decoded word.
// - One threshold setting per group of four consecutive lines.
// - Restore default maps bus bit n to input line n.
// - Trigger level is the threshold of the source line's group.
// - Logic trigger offers edge, width, pattern and timeout.
// - Pattern trigger combines active lines selected by the pattern mask, optionally analog states.
// - Holdoff suppresses further triggers for a programmed time.
// - Each decoded word carries its data and start time.
module pbus_capture import pbus_pkg::*; (
    input wire logic SYS_CLK_I,
    input wire logic SRST_I,
    input wire logic [NLINES-1:0] LINES_I,
    input wire logic [NANALOG-1:0] ANALOG_I,
    input wire logic [NGROUPS*THR_W-1:0] THRESH_I,
    input wire logic [WID_W-1:0] WIDTH_I,
    input wire logic MAP_WR_I,
    input wire logic [SEL_W-1:0] MAP_BIT_I,
    input wire logic [SEL_W-1:0] MAP_LINE_I,
    input wire logic MAP_DEFAULT_I,
    input wire logic CLOCKED_I,
    input wire logic [SEL_W-1:0] CLK_LINE_I,
    input wire logic [SEL_W-1:0] CS_LINE_I,
    input wire logic CS_EN_I,
    input wire logic CS_POL_I,
    input wire slope_t SLOPE_I,
    input wire trig_type_t TRIG_TYPE_I,
    input wire slope_t TRIG_SLOPE_I,
    input wire logic [SEL_W-1:0] TRIG_SRC_I,
    input wire logic [NLINES-1:0] ACTIVE_I,
    input wire logic [NLINES-1:0] PAT_MASK_I,
    input wire logic [NLINES-1:0] PAT_VAL_I,
    input wire logic [NANALOG-1:0] ANA_MASK_I,
    input wire logic [NANALOG-1:0] ANA_VAL_I,
    input wire logic [CNT_W-1:0] WIDTH_MIN_I,
    input wire logic [CNT_W-1:0] TIMEOUT_I,
    input wire logic [CNT_W-1:0] HOLDOFF_I,
    output logic WORD_VALID_O,
    output logic [NLINES-1:0] WORD_DATA_O,
    output logic [TS_W-1:0] WORD_TIME_O,
    output logic [NGROUPS*THR_W-1:0] THRESH_O,
    output logic [THR_W-1:0] TRIG_LEVEL_O,
    output logic TRIG_O
);
    typedef struct packed {
        logic [NLINES-1:0] s1;
        logic [NLINES-1:0] s2;
        logic [NLINES-1:0] prev;
        logic [NANALOG-1:0] a1;
        logic [NANALOG-1:0] a2;
        logic [NLINES-1:0] mprev;
        logic [NLINES*SEL_W-1:0] map;
        logic [WID_W-1:0] width;
        logic [TS_W-1:0] ts;
        logic vld;
        logic [NLINES-1:0] data;
        logic [TS_W-1:0] wtime;
        logic [NGROUPS*THR_W-1:0] thr;
        logic [THR_W-1:0] lvl;
        logic trig;
    } st_t;

    st_t q, d;
    logic [NLINES-1:0] mapped;
    logic clk_now, clk_old, rise, fall, cs_ok, edge_ok, new_word;
    logic [THR_W-1:0] grp_lvl;

    pbus_if tif ();

    // Bits above the bus width read as zero
    for (genvar b = 0; b < NLINES; b++) begin : g_map
        assign mapped[b] = (WID_W'(b) < q.width) ?
            q.s2[q.map[b*SEL_W +: SEL_W]] : 1'b0;
    end

    always_comb begin
        d = q;
        d.s1 = LINES_I;
        d.s2 = q.s1;
        d.prev = q.s2;
        d.a1 = ANALOG_I;
        d.a2 = q.a1;
        d.ts = q.ts + 1;
        d.mprev = mapped;
        if (WIDTH_I < WIDTH_MIN_BITS) begin
            d.width = WIDTH_MIN_BITS;
        end else if (WIDTH_I > WIDTH_MAX_BITS) begin
            d.width = WIDTH_MAX_BITS;
        end else begin
            d.width = WIDTH_I;
        end
        if (MAP_DEFAULT_I) begin
            d.map = MAP_DEFAULT;
        end else if (MAP_WR_I) begin
            d.map[MAP_BIT_I*SEL_W +: SEL_W] = MAP_LINE_I;
        end
        clk_now = q.s2[CLK_LINE_I];
        clk_old = q.prev[CLK_LINE_I];
        rise = clk_now && !clk_old;
        fall = !clk_now && clk_old;
        cs_ok = !CS_EN_I || (q.s2[CS_LINE_I] == CS_POL_I);
        case (SLOPE_I)
            SLOPE_RISE: edge_ok = rise;
            SLOPE_FALL: edge_ok = fall;
            SLOPE_BOTH: edge_ok = rise || fall;
            default: edge_ok = 1'b0;
        endcase
        if (CLOCKED_I) begin
            new_word = edge_ok && cs_ok;
        end else begin
            new_word = mapped != q.mprev;
        end
        d.vld = new_word;
        if (new_word) begin
            d.data = mapped;
            d.wtime = q.ts;
        end
        d.thr = THRESH_I;
        grp_lvl = q.thr[TRIG_SRC_I[SEL_W-1:2]*THR_W +: THR_W];
        d.lvl = grp_lvl;
        d.trig = tif.fire;
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            q <= '0;
            q.map <= MAP_DEFAULT;
            q.width <= WIDTH_RST;
        end else begin
            q <= d;
        end
    end

    assign tif.lines = q.s2;
    assign tif.analog = q.a2;
    assign tif.ttype = TRIG_TYPE_I;
    assign tif.tslope = TRIG_SLOPE_I;
    assign tif.src = TRIG_SRC_I;
    assign tif.active = ACTIVE_I;
    assign tif.pmask = PAT_MASK_I;
    assign tif.pval = PAT_VAL_I;
    assign tif.amask = ANA_MASK_I;
    assign tif.aval = ANA_VAL_I;
    assign tif.width_min = WIDTH_MIN_I;
    assign tif.timeout = TIMEOUT_I;
    assign tif.holdoff = HOLDOFF_I;

    trig_unit u_trig (
        .clk_i(SYS_CLK_I),
        .rst_i(SRST_I),
        .bus(tif)
    );

    assign WORD_VALID_O = q.vld;
    assign WORD_DATA_O = q.data;
    assign WORD_TIME_O = q.wtime;
    assign THRESH_O = q.thr;
    assign TRIG_LEVEL_O = q.lvl;
    assign TRIG_O = q.trig;

    property p_width;
        @(posedge SYS_CLK_I) disable iff (SRST_I)
            q.width >= WIDTH_MIN_BITS && q.width <= WIDTH_MAX_BITS;
    endproperty
    a_width: assert property (p_width) else $error("bus width out of range");

    property p_default;
        @(posedge SYS_CLK_I) disable iff (SRST_I) MAP_DEFAULT_I |=> q.map == MAP_DEFAULT;
    endproperty
    a_default: assert property (p_default) else $error("default map not restored");

    property p_stamp;
        @(posedge SYS_CLK_I) disable iff (SRST_I) q.vld |-> q.wtime == q.ts - 1;
    endproperty
    a_stamp: assert property (p_stamp) else $error("word time stamp wrong");

    property p_cs_block;
        @(posedge SYS_CLK_I) disable iff (SRST_I)
            (CLOCKED_I && CS_EN_I && q.s2[CS_LINE_I] != CS_POL_I) |=> !q.vld;
    endproperty
    a_cs_block: assert property (p_cs_block) else $error("word during inactive cs");

    property p_rise_word;
        @(posedge SYS_CLK_I) disable iff (SRST_I)
            (CLOCKED_I && !CS_EN_I && SLOPE_I == SLOPE_RISE && rise)
            |=> q.vld && q.data == $past(mapped);
    endproperty
    a_rise_word: assert property (p_rise_word) else $error("rising edge word lost");

    property p_fall_only;
        @(posedge SYS_CLK_I) disable iff (SRST_I)
            (CLOCKED_I && SLOPE_I == SLOPE_FALL && !fall) |=> !q.vld;
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("word off falling slope");

    property p_unclocked;
        @(posedge SYS_CLK_I) disable iff (SRST_I)
            (!CLOCKED_I && mapped != q.mprev) |=> q.vld;
    endproperty
    a_unclocked: assert property (p_unclocked) else $error("line change not decoded");

    property p_level;
        @(posedge SYS_CLK_I) disable iff (SRST_I) 1'b1 |=> TRIG_LEVEL_O == $past(grp_lvl);
    endproperty
    a_level: assert property (p_level) else $error("trigger level not group threshold");

    property p_both_fall;
        @(posedge SYS_CLK_I) disable iff (SRST_I)
            (CLOCKED_I && !CS_EN_I && SLOPE_I == SLOPE_BOTH && fall) |=> q.vld;
    endproperty
    a_both_fall: assert property (p_both_fall) else $error("falling edge word lost");

    property p_cs_pass;
        @(posedge SYS_CLK_I) disable iff (SRST_I)
            (CLOCKED_I && CS_EN_I && q.s2[CS_LINE_I] == CS_POL_I &&
            SLOPE_I == SLOPE_RISE && rise) |=> q.vld;
    endproperty
    a_cs_pass: assert property (p_cs_pass) else $error("active chip select word lost");

    property p_thresh;
        @(posedge SYS_CLK_I) disable iff (SRST_I) 1'b1 |=> THRESH_O == $past(THRESH_I);
    endproperty
    a_thresh: assert property (p_thresh) else $error("threshold not passed on");
endmodule : pbus_capture

// ===== rtl/pbus_if.sv
// Carrier between capture top and trigger unit
interface pbus_if;
    import pbus_pkg::*;
    logic [NLINES-1:0] lines;
    logic [NANALOG-1:0] analog;
    trig_type_t ttype;
    slope_t tslope;
    logic [SEL_W-1:0] src;
    logic [NLINES-1:0] active;
    logic [NLINES-1:0] pmask;
    logic [NLINES-1:0] pval;
    logic [NANALOG-1:0] amask;
    logic [NANALOG-1:0] aval;
    logic [CNT_W-1:0] width_min;
    logic [CNT_W-1:0] timeout;
    logic [CNT_W-1:0] holdoff;
    logic fire;
    modport feed (output lines, analog, ttype, tslope, src, active, pmask, pval,
        amask, aval, width_min, timeout, holdoff, input fire);
    modport trig (input lines, analog, ttype, tslope, src, active, pmask, pval,
        amask, aval, width_min, timeout, holdoff, output fire);
endinterface : pbus_if

// ===== rtl/pbus_pkg.sv
// Shared constants and types for the parallel bus capture block
package pbus_pkg;
    localparam int NLINES = 16;
    localparam int SEL_W = 4;
    localparam int NIB_W = 4;
    localparam int NGROUPS = NLINES / NIB_W;
    localparam int THR_W = 10;
    localparam int WID_W = 5;
    localparam int TS_W = 32;
    localparam int CNT_W = 32;
    localparam int NANALOG = 4;
    localparam logic [WID_W-1:0] WIDTH_MIN_BITS = 5'h01;
    localparam logic [WID_W-1:0] WIDTH_MAX_BITS = 5'h10;
    localparam logic [WID_W-1:0] WIDTH_RST = 5'h10;
    // Bus bit n from input line n
    localparam logic [NLINES*SEL_W-1:0] MAP_DEFAULT = 64'hFEDCBA9876543210;
    typedef enum logic [1:0] {
        SLOPE_RISE = 2'h0,
        SLOPE_FALL = 2'h1,
        SLOPE_BOTH = 2'h2
    } slope_t;
    typedef enum logic [3:0] {
        TRIG_EDGE = 4'h1,
        TRIG_WIDTH = 4'h2,
        TRIG_PATTERN = 4'h4,
        TRIG_TIMEOUT = 4'h8
    } trig_type_t;
endpackage : pbus_pkg

// ===== rtl/trig_unit.sv
// Trigger conditions on logic lines with holdoff
module trig_unit import pbus_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    pbus_if.trig bus
);
    typedef struct packed {
        logic lvl;
        logic pat;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] hold;
        logic fire;
    } tst_t;

    tst_t q, d;
    logic lvl, chg, pat, hit, act_lvl;

    always_comb begin
        d = q;
        lvl = bus.lines[bus.src];
        chg = lvl != q.lvl;
        act_lvl = bus.tslope != SLOPE_FALL;
        pat = (((bus.lines ^ bus.pval) & bus.pmask & bus.active) == '0) &&
            (((bus.analog ^ bus.aval) & bus.amask) == '0);
        case (bus.ttype)
            TRIG_EDGE: hit = chg && (bus.tslope == SLOPE_BOTH || lvl == act_lvl);
            TRIG_WIDTH: hit = chg && q.lvl == act_lvl && (q.cnt + 1) >= bus.width_min;
            TRIG_PATTERN: hit = pat && !q.pat;
            TRIG_TIMEOUT: hit = !chg && bus.timeout != '0 && (q.cnt + 1) == bus.timeout;
            default: hit = 1'b0;
        endcase
        d.lvl = lvl;
        d.pat = pat;
        // Saturate so a long idle line cannot wrap into a second timeout
        if (chg) begin
            d.cnt = '0;
        end else if (q.cnt != '1) begin
            d.cnt = q.cnt + 1;
        end
        d.fire = 1'b0;
        if (q.hold != '0) begin
            d.hold = q.hold - 1;
        end else if (hit) begin
            d.fire = 1'b1;
            d.hold = bus.holdoff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bus.fire = q.fire;

    property p_holdoff;
        @(posedge clk_i) disable iff (rst_i) (q.hold != '0) |=> !q.fire;
    endproperty
    a_holdoff: assert property (p_holdoff) else $error("trigger during holdoff");

    property p_hold_load;
        @(posedge clk_i) disable iff (rst_i) $rose(q.fire) |-> q.hold == $past(bus.holdoff);
    endproperty
    a_hold_load: assert property (p_hold_load) else $error("holdoff not loaded");

    property p_pattern;
        @(posedge clk_i) disable iff (rst_i)
            (bus.ttype == TRIG_PATTERN && q.hold == '0 && pat && !q.pat) |=> q.fire;
    endproperty
    a_pattern: assert property (p_pattern) else $error("pattern trigger missed");

    property p_edge;
        @(posedge clk_i) disable iff (rst_i)
            (bus.ttype == TRIG_EDGE && bus.tslope == SLOPE_RISE && !chg) |=> !q.fire;
    endproperty
    a_edge: assert property (p_edge) else $error("edge trigger without edge");

    property p_width_end;
        @(posedge clk_i) disable iff (rst_i) (bus.ttype == TRIG_WIDTH && !chg) |=> !q.fire;
    endproperty
    a_width_end: assert property (p_width_end) else $error("width trigger without pulse end");

    property p_timeout_chg;
        @(posedge clk_i) disable iff (rst_i) (bus.ttype == TRIG_TIMEOUT && chg) |=> !q.fire;
    endproperty
    a_timeout_chg: assert property (p_timeout_chg) else $error("timeout trigger on a change");
endmodule : trig_unit

// ===== sim/pbus_dev.sv
// Behavioural device driving data, chip select and clock lines
module pbus_dev import pbus_pkg::*; (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [7:0] data_i,
    input wire logic cs_i,
    output logic [NLINES-1:0] lines_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial lines_o = '0;
    // Data held around both clock edges, then spoiled so stale data never matches
    always @(negedge clk_i) begin
        if (go_i) begin
            lines_o[7:0] <= data_i;
            lines_o[14] <= cs_i;
            repeat (3) @(negedge clk_i);
            lines_o[15] <= 1'b1;
            repeat (4) @(negedge clk_i);
            lines_o[15] <= 1'b0;
            repeat (2) @(negedge clk_i);
            lines_o[7:0] <= ~data_i;
        end
    end
endmodule : pbus_dev

// ===== sim/tb.sv
// Self-checking bench for the parallel bus capture top
module tb import pbus_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, srst = 1'b1, go = 1'b0, cs = 1'b0, map_wr = 1'b0, map_def = 1'b0;
    logic clocked = 1'b0, cs_en = 1'b0, cs_pol = 1'b0, remap = 1'b0, word_valid, trig;
    logic [7:0] data = 8'h00;
    logic [NLINES-1:0] lines, active = 16'hFFFF, pval = 16'h8000, word_data, first_d;
    logic [NANALOG-1:0] analog = 4'h0, amask = 4'h0;
    logic [NGROUPS*THR_W-1:0] thresh = 40'h0, thresh_o;
    logic [WID_W-1:0] width = 5'h08;
    logic [SEL_W-1:0] map_bit = 4'h0, map_line = 4'h0, tsrc = 4'hF;
    slope_t slope = SLOPE_RISE, tslope = SLOPE_RISE;
    trig_type_t ttype = TRIG_EDGE;
    logic [CNT_W-1:0] wmin = 32'h1, holdoff = 32'h0, tmo = 32'h0;
    logic [TS_W-1:0] word_time, first_t, last_t;
    logic [THR_W-1:0] level;
    logic [31:0] seed = 32'h587A1336;
    int n_mismatch = 0, n_tests = 0, n_words = 0, n_trig = 0;
    always #50 clk = ~clk;
    pbus_dev pbus_dev_i (.clk_i(clk), .go_i(go), .data_i(data), .cs_i(cs), .lines_o(lines));
    pbus_capture pbus_capture_i (
        .SYS_CLK_I(clk), .SRST_I(srst), .LINES_I(lines), .ANALOG_I(analog),
        .THRESH_I(thresh), .WIDTH_I(width), .MAP_WR_I(map_wr), .MAP_BIT_I(map_bit),
        .MAP_LINE_I(map_line), .MAP_DEFAULT_I(map_def), .CLOCKED_I(clocked),
        .CLK_LINE_I(4'hF), .CS_LINE_I(4'hE), .CS_EN_I(cs_en), .CS_POL_I(cs_pol),
        .SLOPE_I(slope), .TRIG_TYPE_I(ttype), .TRIG_SLOPE_I(tslope), .TRIG_SRC_I(tsrc),
        .ACTIVE_I(active), .PAT_MASK_I(16'h8000), .PAT_VAL_I(pval), .ANA_MASK_I(amask),
        .ANA_VAL_I(analog), .WIDTH_MIN_I(wmin), .TIMEOUT_I(tmo), .HOLDOFF_I(holdoff),
        .WORD_VALID_O(word_valid), .WORD_DATA_O(word_data), .WORD_TIME_O(word_time),
        .THRESH_O(thresh_o), .TRIG_LEVEL_O(level), .TRIG_O(trig)
    );
    always @(posedge clk) begin
        if (word_valid === 1'b1) begin
            if (n_words == 0) begin
                first_d = word_data;
                first_t = word_time;
            end
            last_t = word_time;
            n_words++;
        end
        if (trig === 1'b1) n_trig++;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Narrow widths below one still keep bit zero
    function automatic logic [15:0] expect_word(logic [7:0] d, logic [4:0] w);
        logic [15:0] v;
        v = {8'h00, d};
        if (remap) v[0] = d[5];
        return v & 16'((17'h1 << (w == 5'h00 ? 5'h01 : w)) - 17'h1);
    endfunction : expect_word
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s %h", $time, what, got);
        end
    endtask : check
    task automatic send();
        @(negedge clk);
        go <= 1'b1;
        @(negedge clk);
        go <= 1'b0;
        repeat (16) @(negedge clk);
    endtask : send
    task automatic cap(input logic ck, input slope_t sl, input logic en, input logic pol,
        input logic c, input int nexp);
        logic [7:0] r;
        r = 8'(rnd());
        @(negedge clk);
        clocked <= ck;
        slope <= sl;
        cs_en <= en;
        cs_pol <= pol;
        cs <= c;
        width <= ck ? 5'h08 : 5'(rnd() % 9);
        // Bits 0 and 5 always change so the first word is never hidden
        data <= {r[7:6], ~lines[5], r[4:1], ~lines[0]};
        repeat (4) @(negedge clk);
        n_words = 0;
        send();
        check(40'(n_words), 40'(nexp), "word count");
        if (nexp > 0) check(40'(first_d), 40'(expect_word(data, width)), "data");
        if (nexp > 1) check(40'(last_t - first_t), ck ? 40'h4 : 40'h9, "time");
        $display("capture case done, slope %s", sl.name());
    endtask : cap
    task automatic trg(input trig_type_t ty, input logic [31:0] ho, input logic act,
        input int nexp);
        logic [31:0] r;
        r = rnd();
        @(negedge clk);
        ttype <= ty;
        holdoff <= ho;
        tslope <= r[0] ? SLOPE_FALL : SLOPE_RISE;
        wmin <= 32'(r[3:2]) + 32'h1;
        // Shorter than the 14-cycle gap, longer than the pulse and the tail
        tmo <= 32'(r[14:12]) + 32'h6;
        analog <= r[7:4];
        amask <= r[11:8];
        active <= {act, r[26:12]};
        pval <= {1'b1, r[31:17]};
        repeat (40) @(negedge clk);
        n_trig = 0;
        send();
        send();
        check(40'(n_trig), 40'(nexp), "trigger count");
        $display("trigger case %s done", ty.name());
    endtask : trg
    initial begin
        #2000000;
        n_mismatch++;
        $display("unexpected at %0t: watchdog", $time);
        wrap_up();
    end
    initial begin
        repeat (12) @(negedge clk);
        srst <= 1'b0;
        repeat (3) begin
            @(negedge clk);
            thresh <= 40'({rnd(), rnd()});
            tsrc <= 4'(rnd());
            repeat (3) @(negedge clk);
            check(thresh_o, thresh, "threshold");
            check(40'(level), 40'(thresh[tsrc[3:2]*THR_W +: THR_W]), "trigger level");
        end
        tsrc <= 4'hF;
        repeat (6) cap(1'b0, SLOPE_RISE, 1'b0, 1'b0, 1'b0, 2);
        cap(1'b1, SLOPE_RISE, 1'b0, 1'b0, 1'b0, 1);
        cap(1'b1, SLOPE_FALL, 1'b0, 1'b0, 1'b0, 1);
        cap(1'b1, SLOPE_BOTH, 1'b0, 1'b0, 1'b0, 2);
        cap(1'b1, SLOPE_RISE, 1'b1, 1'b1, 1'b0, 0);
        cap(1'b1, SLOPE_RISE, 1'b1, 1'b1, 1'b1, 1);
        cap(1'b1, SLOPE_BOTH, 1'b1, 1'b0, 1'b0, 2);
        cap(1'b1, SLOPE_RISE, 1'b0, 1'b1, 1'b0, 1);
        @(negedge clk);
        map_line <= 4'h5;
        map_wr <= 1'b1;
        @(negedge clk);
        map_wr <= 1'b0;
        remap = 1'b1;
        repeat (2) cap(1'b0, SLOPE_RISE, 1'b0, 1'b0, 1'b0, 2);
        @(negedge clk);
        map_wr <= 1'b1;
        map_def <= 1'b1;
        @(negedge clk);
        map_wr <= 1'b0;
        map_def <= 1'b0;
        remap = 1'b0;
        repeat (2) cap(1'b0, SLOPE_RISE, 1'b0, 1'b0, 1'b0, 2);
        trg(TRIG_EDGE, 32'h0, 1'b1, 2);
        trg(TRIG_WIDTH, 32'h0, 1'b1, 2);
        trg(TRIG_PATTERN, 32'h0, 1'b1, 2);
        trg(TRIG_PATTERN, 32'h0, 1'b0, 0);
        trg(TRIG_TIMEOUT, 32'h0, 1'b1, 1);
        trg(TRIG_EDGE, 32'h1E, 1'b1, 1);
        wrap_up();
    end
endmodule : tb
